// file: pc_stack_core.sv
`timescale 1ns/1ns
// Function
// - Writing the PC low byte loads all 15 PC bits, top from the latch.
// - Call loads low 11 bits from operand, bits 14:11 from latch bits 6:3.
// - Accumulator call loads low byte from accumulator, high part from latch.
// - Branch by accumulator sets PC to PC plus one plus unsigned accumulator.
// - Relative branch sets PC to PC plus one plus the signed low 9 bits of the operand.
// - Return stack has sixteen 15-bit entries, separate from both memories.
// - Calls and interrupts push, returns pop; the high latch stays untouched.
// - With fault reset disabled the stack wraps; push 17 overwrites entry one.
// - Overflow and underflow flags set whether or not fault reset is enabled.
// - Five-bit stack pointer; software selects entries and accesses them via top registers.
// - Push increments pointer then writes; return reads then decrements.
// - With fault reset enabled an overflow or underflow resets, flags still set.
// - Indirect ports have no storage; they reach the pointer's target address.
// - Pointer at an indirect port: read gives zero, write is dropped.
// - Each pointer joins high and low bytes into a 16-bit address.
// - Addresses 0x0000 to 0x1FFF map straight onto banked data addresses.
// - Addresses 0x2000 to 0x2FEF map onto each bank's 80-byte RAM in turn.
// - Linear addresses without implemented RAM read as zero.
// - Common memory never appears inside the linear region.
// - Pointer MSB set addresses program memory; reads give the low byte.
// - Indirect writes into program memory are dropped.
// - Indirect program memory access costs one extra instruction cycle.
// - Every reset source clears the whole program counter.
module pc_stack_core (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic stack_fault_reset_enable_i,
    input wire pc_stack_pkg::exec_t exec_i,
    input wire pc_stack_pkg::bus_req_t bus_i,
    input wire logic [1:0][7:0] dmem_rdata_i,
    input wire logic [1:0][13:0] pmem_rdata_i,
    output logic [7:0] bus_rdata_o,
    output logic [14:0] pc_o,
    output wire logic [1:0][12:0] dmem_raddr_o,
    output wire logic [1:0][14:0] pmem_raddr_o,
    output pc_stack_pkg::dmem_wr_t dmem_wr_o,
    output logic ind_stall_o,
    output logic fault_reset_o
);

    logic [14:0] pc_ff;
    logic [14:0] nxt_pc;
    logic [6:0] latch_ff;
    logic [4:0] sp_ff;
    logic [4:0] nxt_sp;
    logic [1:0] status_ff;
    logic [1:0] nxt_status;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    pc_stack_pkg::dmem_wr_t dwr_ff;
    pc_stack_pkg::dmem_wr_t nxt_dwr;
    logic stall_ff;
    logic fault_ff;
    logic [15:0] ptr_ff [2];
    pc_stack_pkg::ind_target_t target_ff [2];

    pc_stack_pkg::exec_op_t op;
    logic push;
    logic pop;
    logic overflow;
    logic underflow;
    logic fault;
    logic [14:0] push_value;
    logic [14:0] stack_rdata;
    logic [14:0] stack_wdata;
    logic [3:0] stack_waddr;
    logic stack_we;
    logic pc_low_write;
    logic latch_write;
    logic sp_write;
    logic top_low_write;
    logic top_high_write;
    logic status_write;
    logic [1:0] ind_rd;
    logic [1:0] ind_wr;
    logic [1:0] ind_prog;
    logic [1:0][7:0] ind_value;

    function automatic pc_stack_pkg::ind_target_t translate(input logic [15:0] a);
        pc_stack_pkg::ind_target_t t;
        logic [11:0] off;
        logic [5:0] bank;
        logic [6:0] idx;
        t.region = pc_stack_pkg::REGION_VOID;
        t.daddr = a[12:0];
        t.paddr = a[14:0];
        off = 12'(a - pc_stack_pkg::LINEAR_BASE);
        bank = 6'(off / pc_stack_pkg::RAM_BLOCK_BYTES);
        idx = 7'(off % pc_stack_pkg::RAM_BLOCK_BYTES);
        if (a[pc_stack_pkg::PROG_BIT]) begin
            t.region = pc_stack_pkg::REGION_PROG;
        end else if (a < pc_stack_pkg::LINEAR_BASE) begin
            // Port addresses repeat in every bank
            if (a[6:0] == pc_stack_pkg::IND_PORT0_LOW || a[6:0] == pc_stack_pkg::IND_PORT1_LOW) begin
                t.region = pc_stack_pkg::REGION_SELF;
            end else begin
                t.region = pc_stack_pkg::REGION_BANKED;
            end
        end else if (a <= pc_stack_pkg::LINEAR_LAST && off < pc_stack_pkg::LINEAR_IMPL_BYTES) begin
            // Block stays inside 0x20..0x6F of a bank, so common RAM is skipped
            t.region = pc_stack_pkg::REGION_BANKED;
            t.daddr = {bank, 7'(pc_stack_pkg::RAM_BLOCK_START + idx)};
        end
        return t;
    endfunction

    assign op = exec_i.op;
    assign push = op inside {pc_stack_pkg::OP_CALL, pc_stack_pkg::OP_CALL_VIA_ACC,
                             pc_stack_pkg::OP_IRQ_VECTOR};
    assign pop = op inside {pc_stack_pkg::OP_RETURN, pc_stack_pkg::OP_RETURN_LITERAL,
                            pc_stack_pkg::OP_RETURN_INTERRUPT};
    assign overflow = push && sp_ff == pc_stack_pkg::SP_TOP;
    assign underflow = pop && sp_ff == pc_stack_pkg::SP_RESET;
    assign fault = stack_fault_reset_enable_i && (overflow || underflow);
    // Vectoring replaces the instruction at pc_ff, so that one is resumed
    assign push_value = (op == pc_stack_pkg::OP_IRQ_VECTOR) ? pc_ff : pc_ff + 15'h0001;

    assign pc_low_write = bus_i.wr && bus_i.addr == pc_stack_pkg::REG_PC_LOW_BYTE;
    assign latch_write = bus_i.wr && bus_i.addr == pc_stack_pkg::REG_PC_HIGH_LATCH;
    assign sp_write = bus_i.wr && bus_i.addr == pc_stack_pkg::REG_STACK_POINTER;
    assign top_low_write = bus_i.wr && bus_i.addr == pc_stack_pkg::REG_TOP_LOW;
    assign top_high_write = bus_i.wr && bus_i.addr == pc_stack_pkg::REG_TOP_HIGH;
    assign status_write = bus_i.wr && bus_i.addr == pc_stack_pkg::REG_POWER_STATUS;

    return_stack_mem u_stack (
        .core_clk_i(core_clk_i),
        .write_en_i(stack_we),
        .write_addr_i(stack_waddr),
        .write_data_i(stack_wdata),
        .read_addr_i(sp_ff[3:0]),
        .read_data_o(stack_rdata)
    );

    // Per pointer: byte writes, address translation, indirect port value
    for (genvar n = 0; n < 2; n++) begin : g_ptr
        logic [15:0] nxt_ptr;
        logic low_wr;
        logic high_wr;

        assign low_wr = bus_i.wr && bus_i.addr == 7'(pc_stack_pkg::REG_PTR0_LOW
            + 7'(n) * pc_stack_pkg::PTR_STRIDE);
        assign high_wr = bus_i.wr && bus_i.addr == 7'(pc_stack_pkg::REG_PTR0_HIGH
            + 7'(n) * pc_stack_pkg::PTR_STRIDE);
        assign ind_rd[n] = bus_i.rd && bus_i.addr == 7'(pc_stack_pkg::REG_IND_PORT0 + 7'(n));
        assign ind_wr[n] = bus_i.wr && bus_i.addr == 7'(pc_stack_pkg::REG_IND_PORT0 + 7'(n));
        assign ind_prog[n] = target_ff[n].region == pc_stack_pkg::REGION_PROG;
        assign dmem_raddr_o[n] = target_ff[n].daddr;
        assign pmem_raddr_o[n] = target_ff[n].paddr;

        always_comb begin
            nxt_ptr = ptr_ff[n];
            if (low_wr) begin
                nxt_ptr[7:0] = bus_i.wdata;
            end
            if (high_wr) begin
                nxt_ptr[15:8] = bus_i.wdata;
            end
        end

        // Translating the next value keeps the target aligned with the pointer
        always_ff @(posedge core_clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                ptr_ff[n] <= pc_stack_pkg::PTR_RESET;
                target_ff[n] <= '{pc_stack_pkg::REGION_BANKED, 13'h0000, 15'h0000};
            end else begin
                ptr_ff[n] <= nxt_ptr;
                target_ff[n] <= translate(nxt_ptr);
            end
        end

        always_comb begin
            unique case (target_ff[n].region)
                pc_stack_pkg::REGION_BANKED: ind_value[n] = dmem_rdata_i[n];
                pc_stack_pkg::REGION_PROG: ind_value[n] = pmem_rdata_i[n][7:0];
                pc_stack_pkg::REGION_SELF: ind_value[n] = 8'h00;
                pc_stack_pkg::REGION_VOID: ind_value[n] = 8'h00;
            endcase
        end
    end

    always_comb begin
        nxt_pc = pc_ff;
        if (fault) begin
            nxt_pc = pc_stack_pkg::PC_RESET;
        end else if (pc_low_write) begin
            nxt_pc = {latch_ff, bus_i.wdata};
        end else begin
            unique case (op)
                pc_stack_pkg::OP_IDLE: nxt_pc = pc_ff;
                pc_stack_pkg::OP_STEP: nxt_pc = pc_ff + 15'h0001;
                pc_stack_pkg::OP_CALL: nxt_pc = {latch_ff[6:3], exec_i.operand};
                pc_stack_pkg::OP_CALL_VIA_ACC: nxt_pc = {latch_ff, exec_i.accum};
                pc_stack_pkg::OP_BRANCH_BY_ACC: begin
                    nxt_pc = pc_ff + 15'h0001 + {7'h00, exec_i.accum};
                end
                pc_stack_pkg::OP_BRANCH_REL: begin
                    // Wraps freely across 256-word blocks
                    nxt_pc = pc_ff + 15'h0001 + {{(pc_stack_pkg::PC_W - pc_stack_pkg::REL_OFFSET_W)
                        {exec_i.operand[pc_stack_pkg::REL_OFFSET_W - 1]}},
                        exec_i.operand[pc_stack_pkg::REL_OFFSET_W - 1:0]};
                end
                pc_stack_pkg::OP_RETURN,
                pc_stack_pkg::OP_RETURN_LITERAL,
                pc_stack_pkg::OP_RETURN_INTERRUPT: nxt_pc = stack_rdata;
                pc_stack_pkg::OP_IRQ_VECTOR: nxt_pc = pc_stack_pkg::INT_VECTOR;
                default: nxt_pc = pc_ff;
            endcase
        end
    end

    always_comb begin
        nxt_sp = sp_ff;
        if (fault) begin
            nxt_sp = pc_stack_pkg::SP_RESET;
        end else if (push) begin
            nxt_sp = overflow ? pc_stack_pkg::SP_WRAP : sp_ff + 5'h01;
        end else if (pop) begin
            nxt_sp = underflow ? pc_stack_pkg::SP_TOP : sp_ff - 5'h01;
        end else if (sp_write) begin
            nxt_sp = bus_i.wdata[4:0];
        end
    end

    always_comb begin
        stack_we = 1'b0;
        stack_waddr = sp_ff[3:0];
        stack_wdata = stack_rdata;
        if (push && !fault) begin
            stack_we = 1'b1;
            stack_waddr = nxt_sp[3:0];
            stack_wdata = push_value;
        end else if (!push && !pop && (top_low_write || top_high_write)) begin
            // Core stack traffic wins over a software edit in the same cycle
            stack_we = 1'b1;
            if (top_low_write) begin
                stack_wdata[7:0] = bus_i.wdata;
            end
            if (top_high_write) begin
                stack_wdata[14:8] = bus_i.wdata[6:0];
            end
        end
    end

    // Flags survive the stack fault reset; set wins over a software clear
    always_comb begin
        nxt_status = status_ff;
        if (status_write) begin
            nxt_status = status_ff & bus_i.wdata[1:0];
        end
        if (overflow) begin
            nxt_status[pc_stack_pkg::STATUS_OVF_BIT] = 1'b1;
        end
        if (underflow) begin
            nxt_status[pc_stack_pkg::STATUS_UNF_BIT] = 1'b1;
        end
    end

    always_comb begin
        nxt_rdata = 8'h00;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                pc_stack_pkg::REG_IND_PORT0: nxt_rdata = ind_value[0];
                7'(pc_stack_pkg::REG_IND_PORT0 + 7'h01): nxt_rdata = ind_value[1];
                pc_stack_pkg::REG_PC_LOW_BYTE: nxt_rdata = pc_ff[7:0];
                pc_stack_pkg::REG_PTR0_LOW: nxt_rdata = ptr_ff[0][7:0];
                pc_stack_pkg::REG_PTR0_HIGH: nxt_rdata = ptr_ff[0][15:8];
                7'(pc_stack_pkg::REG_PTR0_LOW + pc_stack_pkg::PTR_STRIDE): nxt_rdata = ptr_ff[1][7:0];
                7'(pc_stack_pkg::REG_PTR0_HIGH + pc_stack_pkg::PTR_STRIDE): begin
                    nxt_rdata = ptr_ff[1][15:8];
                end
                pc_stack_pkg::REG_PC_HIGH_LATCH: nxt_rdata = {1'b0, latch_ff};
                pc_stack_pkg::REG_STACK_POINTER: nxt_rdata = {3'h0, sp_ff};
                pc_stack_pkg::REG_TOP_LOW: nxt_rdata = stack_rdata[7:0];
                pc_stack_pkg::REG_TOP_HIGH: nxt_rdata = {1'b0, stack_rdata[14:8]};
                pc_stack_pkg::REG_POWER_STATUS: nxt_rdata = {6'h00, status_ff};
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_comb begin
        nxt_dwr = '0;
        for (int n = 0; n < 2; n++) begin
            // Only banked targets are written; port, void and program ones drop
            if (ind_wr[n] && target_ff[n].region == pc_stack_pkg::REGION_BANKED) begin
                nxt_dwr.we = 1'b1;
                nxt_dwr.addr = target_ff[n].daddr;
                nxt_dwr.data = bus_i.wdata;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_ff <= pc_stack_pkg::PC_RESET;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            latch_ff <= pc_stack_pkg::LATCH_RESET;
        end else if (latch_write) begin
            latch_ff <= bus_i.wdata[6:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sp_ff <= pc_stack_pkg::SP_RESET;
            status_ff <= pc_stack_pkg::STATUS_RESET;
            fault_ff <= 1'b0;
        end else begin
            sp_ff <= nxt_sp;
            status_ff <= nxt_status;
            fault_ff <= fault;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_ff <= 8'h00;
            dwr_ff <= '0;
            stall_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            dwr_ff <= nxt_dwr;
            stall_ff <= |((ind_rd | ind_wr) & ind_prog);
        end
    end

    assign bus_rdata_o = rdata_ff;
    assign pc_o = pc_ff;
    assign dmem_wr_o = dwr_ff;
    assign ind_stall_o = stall_ff;
    assign fault_reset_o = fault_ff;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_call_ok;
        op == pc_stack_pkg::OP_CALL && !fault && !pc_low_write;
    endsequence
    sequence s_return_ok;
        op == pc_stack_pkg::OP_RETURN && !fault && !pc_low_write;
    endsequence

    property p_low_write_load;
        pc_low_write && !fault |=> pc_o == {$past(latch_ff), $past(bus_i.wdata)};
    endproperty
    a_low_write_load: assert property (p_low_write_load) else $error("PC low write load wrong");

    property p_call_target;
        s_call_ok |=> pc_o[10:0] == $past(exec_i.operand) && pc_o[14:11] == $past(latch_ff[6:3]);
    endproperty
    a_call_target: assert property (p_call_target) else $error("Call target wrong");

    property p_acc_call;
        op == pc_stack_pkg::OP_CALL_VIA_ACC && !fault && !pc_low_write
            |=> pc_o == {$past(latch_ff), $past(exec_i.accum)};
    endproperty
    a_acc_call: assert property (p_acc_call) else $error("Accumulator call target wrong");

    property p_branch_acc;
        op == pc_stack_pkg::OP_BRANCH_BY_ACC && !pc_low_write
            |=> pc_o == 15'($past(pc_o) + 15'h0001 + {7'h00, $past(exec_i.accum)});
    endproperty
    a_branch_acc: assert property (p_branch_acc) else $error("Accumulator branch wrong");

    property p_branch_rel;
        op == pc_stack_pkg::OP_BRANCH_REL && !pc_low_write
            |=> pc_o == 15'($past(pc_o) + 15'h0001
                + {{6{$past(exec_i.operand[8])}}, $past(exec_i.operand[8:0])});
    endproperty
    a_branch_rel: assert property (p_branch_rel) else $error("Relative branch wrong");

    property p_call_return;
        s_call_ok ##1 s_return_ok |=> pc_o == 15'($past(pc_o, 2) + 15'h0001)
            && sp_ff == $past(sp_ff, 2) && latch_ff == $past(latch_ff, 2);
    endproperty
    a_call_return: assert property (p_call_return) else $error("Call then return mismatch");

    property p_wrap;
        overflow && !fault |=> sp_ff == pc_stack_pkg::SP_WRAP;
    endproperty
    a_wrap: assert property (p_wrap) else $error("Stack did not wrap");

    property p_flags;
        (overflow |=> status_ff[pc_stack_pkg::STATUS_OVF_BIT])
            and (underflow |=> status_ff[pc_stack_pkg::STATUS_UNF_BIT]);
    endproperty
    a_flags: assert property (p_flags) else $error("Stack flag not set");

    property p_fault_reset;
        fault |=> fault_reset_o && pc_o == pc_stack_pkg::PC_RESET
            && sp_ff == pc_stack_pkg::SP_RESET ##1 (!fault_reset_o || $past(fault));
    endproperty
    a_fault_reset: assert property (p_fault_reset) else $error("Stack fault reset wrong");

    property p_self_zero;
        ind_rd[0] && target_ff[0].region == pc_stack_pkg::REGION_SELF |=> bus_rdata_o == 8'h00;
    endproperty
    a_self_zero: assert property (p_self_zero) else $error("Port self read not zero");

    property p_prog_access;
        (ind_rd[0] || ind_wr[0]) && ind_prog[0] |=> ind_stall_o && !dmem_wr_o.we;
    endproperty
    a_prog_access: assert property (p_prog_access) else $error("Program access handling wrong");

endmodule

// file: pc_stack_pkg.sv
package pc_stack_pkg;

    localparam int PC_W = 15;
    localparam int STACK_DEPTH = 16;
    localparam int REL_OFFSET_W = 9;

    // Register bus map (index = byte address of the plain port)
    localparam logic [6:0] REG_IND_PORT0 = 7'h00;
    localparam logic [6:0] REG_IND_PORT1 = 7'h01;
    localparam logic [6:0] REG_PC_LOW_BYTE = 7'h02;
    localparam logic [6:0] REG_PTR0_LOW = 7'h04;
    localparam logic [6:0] REG_PTR0_HIGH = 7'h05;
    localparam logic [6:0] REG_PC_HIGH_LATCH = 7'h0a;
    localparam logic [6:0] REG_STACK_POINTER = 7'h0d;
    localparam logic [6:0] REG_TOP_LOW = 7'h0e;
    localparam logic [6:0] REG_TOP_HIGH = 7'h0f;
    localparam logic [6:0] REG_POWER_STATUS = 7'h10;
    localparam logic [6:0] PTR_STRIDE = 7'h02;

    // Reset values, stack limits and interrupt vector
    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [6:0] LATCH_RESET = 7'h00;
    localparam logic [4:0] SP_RESET = 5'h1f;
    localparam logic [4:0] SP_TOP = 5'h0f;
    localparam logic [4:0] SP_WRAP = 5'h00;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [1:0] STATUS_RESET = 2'h0;
    localparam logic [14:0] INT_VECTOR = 15'h0004;

    // Power status fields
    localparam int STATUS_OVF_BIT = 1;
    localparam int STATUS_UNF_BIT = 0;

    // Indirect address map
    localparam int PROG_BIT = 15;
    localparam logic [15:0] LINEAR_BASE = 16'h2000;
    localparam logic [15:0] LINEAR_LAST = 16'h2fef;
    localparam logic [11:0] RAM_BLOCK_BYTES = 12'h050;
    localparam logic [6:0] RAM_BLOCK_START = 7'h20;
    localparam logic [11:0] LINEAR_IMPL_BYTES = 12'h190;
    localparam logic [6:0] IND_PORT0_LOW = 7'h00;
    localparam logic [6:0] IND_PORT1_LOW = 7'h01;

    typedef enum logic [3:0] {
        OP_IDLE,
        OP_STEP,
        OP_CALL,
        OP_CALL_VIA_ACC,
        OP_BRANCH_BY_ACC,
        OP_BRANCH_REL,
        OP_RETURN,
        OP_RETURN_LITERAL,
        OP_RETURN_INTERRUPT,
        OP_IRQ_VECTOR
    } exec_op_t;

    typedef struct packed {
        exec_op_t op;
        logic [10:0] operand;
        logic [7:0] accum;
    } exec_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef enum logic [1:0] {
        REGION_BANKED,
        REGION_VOID,
        REGION_PROG,
        REGION_SELF
    } region_t;

    typedef struct packed {
        region_t region;
        logic [12:0] daddr;
        logic [14:0] paddr;
    } ind_target_t;

    typedef struct packed {
        logic we;
        logic [12:0] addr;
        logic [7:0] data;
    } dmem_wr_t;

endpackage

// file: return_stack_mem.sv
`timescale 1ns/1ns
module return_stack_mem (
    input wire logic core_clk_i,
    input wire logic write_en_i,
    input wire logic [3:0] write_addr_i,
    input wire logic [14:0] write_data_i,
    input wire logic [3:0] read_addr_i,
    output logic [14:0] read_data_o
);

    // Held apart from both memories; contents are not reset
    logic [14:0] entry_mem [pc_stack_pkg::STACK_DEPTH];

    always_ff @(posedge core_clk_i) begin
        if (write_en_i) begin
            entry_mem[write_addr_i] <= write_data_i;
        end
    end

    assign read_data_o = entry_mem[read_addr_i];

endmodule

// file: mem_model.sv
`timescale 1ns/1ns
module mem_model (
    input wire logic [1:0][12:0] dmem_raddr_i,
    input wire logic [1:0][14:0] pmem_raddr_i,
    output logic [1:0][7:0] dmem_rdata_o,
    output logic [1:0][13:0] pmem_rdata_o
);
    // Contents follow the address so every indirect read is predictable
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            dmem_rdata_o[n] = dmem_raddr_i[n][7:0] ^ 8'h5a;
            pmem_rdata_o[n] = {pmem_raddr_i[n][5:0], pmem_raddr_i[n][7:0] ^ 8'ha5};
        end
    end
endmodule

// file: testbench.sv
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic fen = 1'b0;
    pc_stack_pkg::exec_t exec = '0;
    pc_stack_pkg::bus_req_t bus = '0;
    logic [1:0][7:0] drd;
    logic [1:0][13:0] prd;
    logic [7:0] rdata;
    logic [14:0] pc;
    logic [1:0][12:0] dra;
    logic [1:0][14:0] pra;
    pc_stack_pkg::dmem_wr_t dwr;
    logic stall;
    logic fault;
    logic [7:0] rv;
    logic st;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;

    always #50 clk = ~clk;

    pc_stack_core u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .stack_fault_reset_enable_i(fen),
        .exec_i(exec), .bus_i(bus), .dmem_rdata_i(drd), .pmem_rdata_i(prd),
        .bus_rdata_o(rdata), .pc_o(pc), .dmem_raddr_o(dra), .pmem_raddr_o(pra),
        .dmem_wr_o(dwr), .ind_stall_o(stall), .fault_reset_o(fault));
    mem_model u_mem (.dmem_raddr_i(dra), .pmem_raddr_i(pra), .dmem_rdata_o(drd),
        .pmem_rdata_o(prd));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask

    task automatic rd(input logic [6:0] a);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        bus <= '0;
        #1;
        rv = rdata;
        st = stall;
    endtask

    task automatic ex(input pc_stack_pkg::exec_op_t op, input logic [10:0] o,
                      input logic [7:0] acc);
        @(posedge clk);
        exec <= '{op: op, operand: o, accum: acc};
        @(posedge clk);
        exec <= '0;
        #1;
    endtask

    task automatic test_flow();
        chk(pc, 16'h0000);
        wr(7'h0a, 8'h08);
        ex(pc_stack_pkg::OP_CALL, 11'h123, 8'h00);
        chk(pc, 16'h0923);
        ex(pc_stack_pkg::OP_CALL_VIA_ACC, 11'h000, 8'h55);
        chk(pc, 16'h0855);
        ex(pc_stack_pkg::OP_BRANCH_BY_ACC, 11'h000, 8'hf0);
        chk(pc, 16'h0946);
        ex(pc_stack_pkg::OP_BRANCH_REL, 11'h1fe, 8'h00);
        chk(pc, 16'h0945);
        wr(7'h02, 8'h77);
        chk(pc, 16'h0877);
        rd(7'h0d);
        chk(rv, 16'h0001);
        rd(7'h0a);
        chk(rv, 16'h0008);
        ex(pc_stack_pkg::OP_RETURN, 11'h000, 8'h00);
        chk(pc, 16'h0924);
        ex(pc_stack_pkg::OP_RETURN_LITERAL, 11'h000, 8'h00);
        chk(pc, 16'h0001);
        rd(7'h0d);
        chk(rv, 16'h001f);
        ex(pc_stack_pkg::OP_IRQ_VECTOR, 11'h000, 8'h00);
        chk(pc, 16'h0004);
        ex(pc_stack_pkg::OP_RETURN_INTERRUPT, 11'h000, 8'h00);
        chk(pc, 16'h0001);
        // Call and return on adjacent edges
        @(posedge clk);
        exec <= '{op: pc_stack_pkg::OP_CALL, operand: 11'h0ab, accum: 8'h00};
        @(posedge clk);
        exec <= '{op: pc_stack_pkg::OP_RETURN, operand: 11'h000, accum: 8'h00};
        @(posedge clk);
        exec <= '0;
        #1;
        chk(pc, 16'h0002);
        $display("test_flow done");
    endtask

    task automatic test_indirect();
        wr(7'h04, 8'h34);
        wr(7'h05, 8'h20);
        rd(7'h00);
        chk(dra[0], 16'h0054);
        chk(rv, 16'h000e);
        chk(st, 16'h0000);
        wr(7'h00, 8'hc3);
        chk(dwr.we, 16'h0001);
        chk(dwr.addr, 16'h0054);
        chk(dwr.data, 16'h00c3);
        wr(7'h04, 8'h50);
        chk(dra[0], 16'h00a0);
        wr(7'h04, 8'h90);
        wr(7'h05, 8'h21);
        rd(7'h00);
        chk(rv, 16'h0000);
        wr(7'h04, 8'h23);
        wr(7'h05, 8'h01);
        chk(dra[0], 16'h0123);
        wr(7'h04, 8'h12);
        wr(7'h05, 8'h80);
        chk(pra[0], 16'h0012);
        rd(7'h00);
        chk(rv, 16'h00b7);
        chk(st, 16'h0001);
        wr(7'h00, 8'hff);
        chk(dwr.we, 16'h0000);
        wr(7'h04, 8'h01);
        wr(7'h05, 8'h00);
        rd(7'h00);
        chk(rv, 16'h0000);
        wr(7'h00, 8'hff);
        chk(dwr.we, 16'h0000);
        wr(7'h06, 8'h45);
        wr(7'h07, 8'h00);
        chk(dra[1], 16'h0045);
        rd(7'h01);
        chk(rv, 16'h001f);
        $display("test_indirect done");
    endtask

    task automatic test_stack();
        for (int i = 0; i < 17; i++) begin
            ex(pc_stack_pkg::OP_CALL, 11'(i), 8'h00);
        end
        rd(7'h10);
        chk(rv, 16'h0002);
        rd(7'h0d);
        chk(rv, 16'h0000);
        rd(7'h0e);
        chk(rv, 16'h0010);
        wr(7'h10, 8'h00);
        @(posedge clk);
        fen <= 1'b1;
        wr(7'h0d, 8'h0f);
        ex(pc_stack_pkg::OP_CALL, 11'h055, 8'h00);
        chk({fault, pc}, 16'h8000);
        ex(pc_stack_pkg::OP_RETURN, 11'h000, 8'h00);
        chk(fault, 16'h0001);
        rd(7'h10);
        chk(rv, 16'h0003);
        rd(7'h0d);
        chk(rv, 16'h001f);
        wr(7'h0e, 8'hab);
        rd(7'h0e);
        chk(rv, 16'h00ab);
        $display("test_stack done");
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Guards against a hung run; fails after 3000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            test_done();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        test_flow();
        test_indirect();
        test_stack();
        test_done();
    end
endmodule
